// ===== core/jhs_pkg.sv
/*
  Shared constants and types of the jog and homing sequencer.
  Assumes a 50 MHz drive clock and six point-select lines.
*/
package jhs_pkg;

  // Point and position widths
  localparam int PT_W  = 6;
  localparam int POS_W = 32;

  // Trip codes
  localparam logic [7:0] FC_NONE   = 8'h00;
  localparam logic [7:0] FC_HOMING = 8'h44;
  localparam logic [7:0] FC_UNDEF  = 8'h45;
  localparam logic [7:0] FC_OVF    = 8'h46;
  localparam logic [7:0] FC_OT     = 8'h47;
  localparam logic [7:0] FC_LIMIT  = 8'h48;

  // Position range, symmetric around zero
  localparam logic signed [POS_W-1:0] POS_MAX = 32'sh7FFFFFFF;
  localparam logic signed [POS_W-1:0] POS_MIN = 32'sh80000001;

  // Power-up homing settings
  localparam logic [1:0] ABS_HOMED_A = 2'h0;
  localparam logic [1:0] ABS_HOMED_B = 2'h2;
  localparam logic       HSKIP_ON    = 1'h1;

  // Point decode
  localparam logic [2:0]      PT_BASE_BITS = 3'h3;
  localparam logic [PT_W-1:0] PT_JOG_FWD   = 6'h01;
  localparam logic [PT_W-1:0] PT_JOG_REV   = 6'h02;
  localparam logic [PT_W-1:0] PCODE_RST    = 6'h00;
  localparam logic [PT_W-1:0] PCODE_HOMED  = 6'h3F;

  // Multi-function input assignment
  localparam logic [1:0] MF_NONE    = 2'h0;
  localparam logic [1:0] MF_JOG_FWD = 2'h1;
  localparam logic [1:0] MF_JOG_REV = 2'h2;

  // Shared output selection
  localparam logic OUT_SEL_POSITIONING_COMPLETE = 1'h0;

  // Homing type, values 0 to 7 in this order
  typedef enum logic [2:0] {
    HT_SENSOR_Z_FRONT, HT_SENSOR_FRONT, HT_SENSOR_Z_REAR, HT_LIMIT_Z,
    HT_LIMIT, HT_Z_ONLY, HT_BUMPING, HT_DATA_SET
  } jhs_home_type_t;

  typedef enum logic [2:0] {
    CMD_NONE, CMD_STEP, CMD_JOG_FWD, CMD_JOG_REV, CMD_HOME
  } jhs_cmd_t;

  // Configuration settings
  typedef struct packed {
    logic [15:0]             jog_low_speed;
    logic [15:0]             jog_high_speed;
    logic [15:0]             jog_acceleration;
    logic [15:0]             jog_deceleration;
    logic                    wrap_around_permit;
    logic [1:0]              overtravel_stop_setting;
    logic signed [POS_W-1:0] max_plus_travel;
    logic signed [POS_W-1:0] max_minus_travel;
    logic signed [POS_W-1:0] home_offset_value;
    logic [1:0]              absolute_encoder_setting;
    logic                    homing_skip_setting;
    jhs_home_type_t          homing_type_setting;
    logic                    control_mode_setting;   // 1: full-closed
    logic [1:0]              input_point_count_select;
    logic                    output_signal_select;
    logic [1:0]              mf_one_assign;
    logic [1:0]              mf_two_assign;
  } jhs_cfg_t;

  // Status from the motion engine
  typedef struct packed {
    logic                    pos_inc;
    logic                    pos_dec;
    logic                    motion_stopped;
    logic                    home_done_ok;
    logic                    home_abort;
    logic                    step_done;
    logic                    in_decel;
    logic                    positioned;
    logic                    ot_fwd;
    logic                    ot_rev;
    logic                    stop_cmd;
    logic                    alarm_in;
    logic                    alarm_clear;
    logic                    autotune_run;
    logic                    freq_meas_run;
    logic signed [POS_W-1:0] abs_position;
  } jhs_motion_t;

  // Commands to the motion engine
  typedef struct packed {
    logic jog_fwd;
    logic jog_rev;
    logic decel_req;
    logic ot_decel;
    logic home_start;
    logic step_start;
    logic alarm_stop;
  } jhs_drive_t;

endpackage : jhs_pkg

// ===== core/jhs_cmd_decode.sv
/*
  Decodes the live point and multi-function inputs into one command.
  Assumes inputs are already held stable by the caller.
*/
`timescale 1ns/1ps
`default_nettype none
module jhs_cmd_decode (
  input  wire logic [5:0] points,
  input  wire logic [1:0] count_sel,
  input  wire logic       mf_one,
  input  wire logic       mf_two,
  input  wire logic [1:0] mf_one_assign,
  input  wire logic [1:0] mf_two_assign,
  output jhs_pkg::jhs_cmd_t cmd
);
  import jhs_pkg::*;

  // Highest point for the selected input count
  function automatic logic [PT_W-1:0] max_point(input logic [1:0] sel);
    logic [PT_W:0] span;
    span = 7'(1) << (PT_BASE_BITS + 3'(sel));
    return PT_W'(span - 7'(1));
  endfunction : max_point

  // Jog requested by a multi-function input
  function automatic logic mf_is_jog(input logic a, input logic [1:0] as);
    return a && (as == MF_JOG_FWD || as == MF_JOG_REV);
  endfunction : mf_is_jog

  logic [PT_W-1:0] top;
  logic            j1;
  logic            j2;

  // Multi-function jog wins over point select
  always_comb begin
    top = max_point(count_sel);
    j1  = mf_is_jog(mf_one, mf_one_assign);
    j2  = mf_is_jog(mf_two, mf_two_assign);
    cmd = CMD_NONE;
    if (j1 && j2) begin
      cmd = CMD_NONE;
    end else if (j1) begin
      cmd = (mf_one_assign == MF_JOG_FWD) ? CMD_JOG_FWD : CMD_JOG_REV;
    end else if (j2) begin
      cmd = (mf_two_assign == MF_JOG_FWD) ? CMD_JOG_FWD : CMD_JOG_REV;
    end else if (points == top) begin
      cmd = CMD_HOME;
    end else if (points == top - PT_JOG_FWD) begin
      cmd = CMD_JOG_FWD;
    end else if (points == top - PT_JOG_REV) begin
      cmd = CMD_JOG_REV;
    end else if (points != PCODE_RST && points < top) begin
      cmd = CMD_STEP;
    end
  end

endmodule : jhs_cmd_decode
`default_nettype wire

// ===== core/jhs_pos_counter.sv
/*
  Signed current position with overflow trip or wrap-around.
  Assumes at most one of inc and dec per cycle; load wins.
*/
`timescale 1ns/1ps
`default_nettype none
module jhs_pos_counter (
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire logic                inc,
  input  wire logic                dec,
  input  wire logic                load,
  input  wire logic signed [31:0]  load_val,
  input  wire logic                wrap_permit,
  output logic signed [31:0]       pos_q,
  output logic                     ovf_q
);
  import jhs_pkg::*;

  // Count, wrap or hold at the range end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pos_q <= 32'sh00000000;
    end else if (load) begin
      pos_q <= load_val;
    end else if (inc) begin
      if (pos_q != POS_MAX) begin
        pos_q <= pos_q + 32'sh00000001;
      end else if (wrap_permit) begin
        pos_q <= POS_MIN;
      end
    end else if (dec) begin
      if (pos_q != POS_MIN) begin
        pos_q <= pos_q - 32'sh00000001;
      end else if (wrap_permit) begin
        pos_q <= POS_MAX;
      end
    end
  end

  // Overflow pulse, suppressed when wrap is permitted
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ovf_q <= 1'b0;
    end else begin
      ovf_q <= !load && !wrap_permit &&
               ((inc && pos_q == POS_MAX) || (dec && pos_q == POS_MIN));
    end
  end

endmodule : jhs_pos_counter
`default_nettype wire

// ===== core/jhs_sequencer.sv
/*
  Jog and homing command sequencer of the servo drive.
  Assumes the host and motion engine signals are synchronous to clk.
*/
// Function
// - Zero jog speed or ramp trips code 69
// - Position overflow beyond range during jog trips code 70
// - Wrap permit suppresses overflow, position wraps
// - Homed jog into over-travel trips code 71
// - Unhomed jog over-travel decelerates, no fault
// - Homed jog past travel limits trips 72
// - External jog is high-speed forward or reverse
// - Both multi-function jogs active: no motion
// - Stop-command jog end keeps position codes
// - Step operation needs homing complete first
// - Absolute setting 0 or 2 homes at power-up
// - Homing skip homes, loads home offset
// - Alarm clears homing complete
// - Homing start clears; only normal finish sets
// - Auto-tuning or response measurement clears homing
// - Homing type setting decodes eight modes
// - Full-closed rejects Z homing, code 68
// - Busy off while executing, until strobe opens
// - Busy returning on marks completion
// - Homing success drives all position codes on
// - Shared output selects positioned or decelerating
// - Jog runs while strobe closed, stops on open
`timescale 1ns/1ps
`default_nettype none
module jhs_sequencer (
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire logic                 command_strobe,
  input  wire logic [5:0]           point_select_inputs,
  input  wire logic                 multi_function_input_one,
  input  wire logic                 multi_function_input_two,
  input  wire jhs_pkg::jhs_cfg_t    cfg,
  input  wire jhs_pkg::jhs_motion_t mot,
  output logic                      busy_on_q,
  output logic [5:0]                position_code_outputs_q,
  output logic                      shared_out_q,
  output jhs_pkg::jhs_drive_t       drive_q,
  output jhs_pkg::jhs_home_type_t   home_type_q,
  output logic [5:0]                step_point_q,
  output logic                      fault_active_q,
  output logic [7:0]                fault_code_q,
  output logic                      homing_complete_q,
  output logic signed [31:0]        current_position_q
);
  import jhs_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE, ST_JOG, ST_JOG_STOP, ST_HOME, ST_STEP, ST_HOLD, ST_FAULT
  } jhs_state_t;

  // Homing types that need the Z phase
  function automatic logic uses_z(input jhs_home_type_t t);
    return t == HT_SENSOR_Z_FRONT || t == HT_SENSOR_Z_REAR ||
           t == HT_LIMIT_Z || t == HT_Z_ONLY;
  endfunction : uses_z

  jhs_state_t      state_q;
  jhs_state_t      state_d;
  jhs_cmd_t        cmd_now;
  jhs_cmd_t        cmd_q;
  logic            strobe_q;
  logic            strobe_rise;
  logic            init_q;
  logic            stop_by_cmd_q;
  logic            pend_q;
  logic [PT_W-1:0] pend_val_q;
  logic [PT_W-1:0] point_q;
  logic            ovf;
  logic            fault_hit;
  logic [7:0]      fault_code_d;
  logic            jog_zero;
  logic            ot_dir;
  logic            over_limit;
  logic            home_reject;
  logic            start_home;
  logic            start_step;
  logic            start_jog;
  logic            load_pos;
  logic signed [31:0] load_val;

  // Decoder sees live inputs, result latched at the strobe edge
  jhs_cmd_decode u_decode (
    .points        (point_select_inputs),
    .count_sel     (cfg.input_point_count_select),
    .mf_one        (multi_function_input_one),
    .mf_two        (multi_function_input_two),
    .mf_one_assign (cfg.mf_one_assign),
    .mf_two_assign (cfg.mf_two_assign),
    .cmd           (cmd_now)
  );

  // Position load at power-up only
  assign load_pos = init_q &&
                    (cfg.homing_skip_setting == HSKIP_ON ||
                     cfg.absolute_encoder_setting == ABS_HOMED_A ||
                     cfg.absolute_encoder_setting == ABS_HOMED_B);
  assign load_val = (cfg.homing_skip_setting == HSKIP_ON) ?
                    cfg.home_offset_value : mot.abs_position;

  jhs_pos_counter u_pos (
    .clk         (clk),
    .rst_n       (rst_n),
    .inc         (mot.pos_inc),
    .dec         (mot.pos_dec),
    .load        (load_pos),
    .load_val    (load_val),
    .wrap_permit (cfg.wrap_around_permit),
    .pos_q       (current_position_q),
    .ovf_q       (ovf)
  );

  // Strobe closing edge
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      strobe_q <= 1'b0;
    end else begin
      strobe_q <= command_strobe;
    end
  end
  assign strobe_rise = command_strobe && !strobe_q;

  // Start qualification in idle
  assign start_home = state_q == ST_IDLE && strobe_rise && cmd_now == CMD_HOME;
  assign start_step = state_q == ST_IDLE && strobe_rise && cmd_now == CMD_STEP &&
                      homing_complete_q;
  assign start_jog  = state_q == ST_IDLE && strobe_rise &&
                      (cmd_now == CMD_JOG_FWD || cmd_now == CMD_JOG_REV);
  assign home_reject = cfg.control_mode_setting &&
                       uses_z(cfg.homing_type_setting);

  // Protection checks
  always_comb begin
    jog_zero = cfg.jog_low_speed == 16'h0000 || cfg.jog_high_speed == 16'h0000 ||
               cfg.jog_acceleration == 16'h0000 ||
               cfg.jog_deceleration == 16'h0000;
    ot_dir = (cmd_q == CMD_JOG_FWD) ? mot.ot_fwd : mot.ot_rev;
    over_limit = current_position_q > cfg.max_plus_travel ||
                 current_position_q < -cfg.max_minus_travel;
    fault_hit = 1'b0;
    fault_code_d = FC_NONE;
    if (start_home && home_reject) begin
      fault_hit = 1'b1;
      fault_code_d = FC_HOMING;
    end else if (start_jog && jog_zero) begin
      fault_hit = 1'b1;
      fault_code_d = FC_UNDEF;
    end else if (state_q == ST_JOG || state_q == ST_JOG_STOP) begin
      if (ovf) begin
        fault_hit = 1'b1;
        fault_code_d = FC_OVF;
      end else if (homing_complete_q && ot_dir) begin
        fault_hit = 1'b1;
        fault_code_d = FC_OT;
      end else if (homing_complete_q && over_limit) begin
        fault_hit = 1'b1;
        fault_code_d = FC_LIMIT;
      end
    end
  end

  // Sequencer state
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: begin
        if (fault_hit) begin
          state_d = ST_FAULT;
        end else if (start_home) begin
          state_d = ST_HOME;
        end else if (start_step) begin
          state_d = ST_STEP;
        end else if (start_jog) begin
          state_d = ST_JOG;
        end
      end
      ST_JOG: begin
        if (fault_hit) begin
          state_d = ST_FAULT;
        end else if (!command_strobe || mot.stop_cmd ||
                     (!homing_complete_q && ot_dir)) begin
          state_d = ST_JOG_STOP;
        end
      end
      ST_JOG_STOP: begin
        if (fault_hit) begin
          state_d = ST_FAULT;
        end else if (mot.motion_stopped) begin
          state_d = ST_HOLD;
        end
      end
      ST_HOME: begin
        if (mot.home_done_ok || mot.home_abort || mot.stop_cmd) begin
          state_d = ST_HOLD;
        end
      end
      ST_STEP: begin
        if (mot.step_done || mot.stop_cmd) begin
          state_d = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (!command_strobe) begin
          state_d = ST_IDLE;
        end
      end
      ST_FAULT: begin
        if (mot.alarm_clear) begin
          state_d = ST_HOLD;
        end
      end
    endcase
    if (mot.alarm_in && state_q != ST_FAULT) begin
      state_d = ST_FAULT;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Command and point sampled once at strobe closing
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cmd_q   <= CMD_NONE;
      point_q <= PCODE_RST;
    end else if (state_q == ST_IDLE && strobe_rise) begin
      cmd_q   <= cmd_now;
      point_q <= point_select_inputs;
    end
  end

  // Remember whether a jog ended by a stop command
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stop_by_cmd_q <= 1'b0;
    end else if (state_q == ST_JOG && state_d == ST_JOG_STOP) begin
      stop_by_cmd_q <= mot.stop_cmd;
    end
  end

  // Pending position code, shown when busy returns on
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pend_q     <= 1'b0;
      pend_val_q <= PCODE_RST;
    end else if (state_d == ST_FAULT) begin
      pend_q <= 1'b0;
    end else if (state_q == ST_HOME && mot.home_done_ok && !mot.stop_cmd &&
                 !mot.home_abort) begin
      pend_q     <= 1'b1;
      pend_val_q <= PCODE_HOMED;
    end else if (state_q == ST_STEP && mot.step_done && !mot.stop_cmd) begin
      pend_q     <= 1'b1;
      pend_val_q <= point_q;
    end else if (state_q == ST_JOG_STOP && state_d == ST_HOLD) begin
      pend_q     <= !stop_by_cmd_q;
      pend_val_q <= point_q;
    end else if (state_q == ST_HOLD && state_d == ST_IDLE) begin
      pend_q <= 1'b0;
    end
  end

  // Position codes change in the cycle busy returns on
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      position_code_outputs_q <= PCODE_RST;
    end else if (state_q == ST_HOLD && state_d == ST_IDLE && pend_q) begin
      position_code_outputs_q <= pend_val_q;
    end
  end

  // Busy transistor off from command start until strobe reopens
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      busy_on_q <= 1'b1;
    end else begin
      busy_on_q <= (state_d == ST_IDLE);
    end
  end

  // Trip latch
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fault_active_q <= 1'b0;
      fault_code_q   <= FC_NONE;
    end else if (fault_hit) begin
      fault_active_q <= 1'b1;
      fault_code_q   <= fault_code_d;
    end else if (mot.alarm_in) begin
      fault_active_q <= 1'b1;
    end else if (state_q == ST_FAULT && mot.alarm_clear) begin
      fault_active_q <= 1'b0;
      fault_code_q   <= FC_NONE;
    end
  end

  // Power-up evaluation happens once after reset release
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      init_q <= 1'b1;
    end else begin
      init_q <= 1'b0;
    end
  end

  // Homing complete state; any clearing event beats a normal finish
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      homing_complete_q <= 1'b0;
    end else if (init_q) begin
      homing_complete_q <= load_pos;
    end else if (fault_hit || mot.alarm_in) begin
      homing_complete_q <= 1'b0;
    end else if (mot.autotune_run || mot.freq_meas_run) begin
      homing_complete_q <= 1'b0;
    end else if (start_home) begin
      homing_complete_q <= 1'b0;
    end else if (state_q == ST_HOME && mot.home_done_ok && !mot.home_abort &&
                 !mot.stop_cmd) begin
      homing_complete_q <= 1'b1;
    end
  end

  // Commands to the motion engine
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      drive_q      <= '0;
      home_type_q  <= HT_SENSOR_Z_FRONT;
      step_point_q <= PCODE_RST;
    end else begin
      drive_q.jog_fwd    <= state_d == ST_JOG && cmd_q == CMD_JOG_FWD;
      drive_q.jog_rev    <= state_d == ST_JOG && cmd_q == CMD_JOG_REV;
      drive_q.decel_req  <= state_d == ST_JOG_STOP;
      drive_q.ot_decel   <= state_d == ST_JOG_STOP && !homing_complete_q &&
                            ot_dir;
      drive_q.home_start <= start_home && !fault_hit;
      drive_q.step_start <= start_step && !fault_hit;
      drive_q.alarm_stop <= state_d == ST_FAULT;
      if (start_home) begin
        home_type_q <= cfg.homing_type_setting;
      end
      if (start_step) begin
        step_point_q <= point_select_inputs;
      end
    end
  end

  // Shared positioned or decelerating output
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      shared_out_q <= 1'b0;
    end else begin
      shared_out_q <= (cfg.output_signal_select == OUT_SEL_POSITIONING_COMPLETE) ?
                      mot.positioned : mot.in_decel;
    end
  end

endmodule : jhs_sequencer
`default_nettype wire

// ===== verification/jhs_checker.sv
/*
  Port-level assertions of the jog and homing sequencer.
  Assumes binding to jhs_sequencer, one clock.
*/
`timescale 1ns/1ps
`default_nettype none
module jhs_checker
  import jhs_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        command_strobe,
  input wire logic        multi_function_input_one,
  input wire logic        multi_function_input_two,
  input wire jhs_cfg_t    cfg,
  input wire jhs_motion_t mot,
  input wire logic        busy_on_q,
  input wire logic [5:0]  position_code_outputs_q,
  input wire logic        shared_out_q,
  input wire jhs_drive_t  drive_q,
  input wire logic [7:0]  fault_code_q,
  input wire logic        fault_active_q,
  input wire logic        homing_complete_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Busy timing against the strobe
  a_busy_hold_strobe: assert property (!busy_on_q && command_strobe |=> !busy_on_q)
    else $error("busy on, strobe closed");
  a_busy_ret_open: assert property ($rose(busy_on_q) |-> !$past(command_strobe))
    else $error("busy rose with strobe closed");
  // Homing state and codes
  a_home_clears: assert property (drive_q.home_start |-> !homing_complete_q)
    else $error("homed at homing start");
  a_home_codes: assert property ($rose(homing_complete_q) ##1 $rose(busy_on_q)
    |-> position_code_outputs_q == PCODE_HOMED)
    else $error("codes not all on after homing");
  a_step_homed: assert property (drive_q.step_start |-> homing_complete_q)
    else $error("step started unhomed");
  // Shared output and jog control
  a_shared_sel: assert property ($past(rst_n) |-> shared_out_q == ($past(
    cfg.output_signal_select) ? $past(mot.in_decel) : $past(mot.positioned)))
    else $error("shared output wrong source");
  a_jog_stop: assert property (drive_q.jog_fwd && !command_strobe |=> !drive_q.jog_fwd)
    else $error("jog kept after strobe open");
  a_homed_trips: assert property ($rose(fault_active_q) && (fault_code_q == FC_LIMIT
    || fault_code_q == FC_OT) |-> $past(homing_complete_q))
    else $error("travel trip while unhomed");
  a_both_mf: assert property ($rose(command_strobe) && busy_on_q && !fault_active_q
    && cfg.mf_one_assign == MF_JOG_FWD && cfg.mf_two_assign == MF_JOG_REV
    && multi_function_input_one && multi_function_input_two |=> busy_on_q)
    else $error("both jogs started a command");
  // Main scenarios
  c_home: cover property (drive_q.home_start);
  c_jog: cover property (drive_q.jog_fwd ##1 drive_q.decel_req);
  c_limit: cover property (fault_code_q == FC_LIMIT);
endmodule : jhs_checker

bind jhs_sequencer jhs_checker u_chk (.clk(clk), .rst_n(rst_n),
  .command_strobe(command_strobe), .multi_function_input_one(multi_function_input_one),
  .multi_function_input_two(multi_function_input_two), .cfg(cfg), .mot(mot),
  .busy_on_q(busy_on_q), .position_code_outputs_q(position_code_outputs_q),
  .shared_out_q(shared_out_q), .drive_q(drive_q), .fault_code_q(fault_code_q),
  .fault_active_q(fault_active_q), .homing_complete_q(homing_complete_q));
`default_nettype wire

// ===== verification/jhs_host_model.sv
/*
  Host controller model: presents a point, closes and reopens the strobe.
  Assumes the bench calls cmd at a falling edge.
*/
`timescale 1ns/1ps
`default_nettype none
module jhs_host_model #(
  parameter int SETTLE_CYC = 4  // Shortened point settle time
) (
  input  wire logic clk,
  input  wire logic busy_on_q,
  output var logic  command_strobe,
  output var logic [5:0] point_select_inputs
);
  initial command_strobe = 1'b0;
  initial point_select_inputs = 6'h00;

  // Point, settle, close, wait for busy off, hold, reopen
  task automatic cmd(input logic [5:0] pt, input int hold);
    int n;
    @(negedge clk) point_select_inputs = pt;
    repeat (SETTLE_CYC) @(negedge clk);
    command_strobe = 1'b1;
    for (n = 0; n < 8 && busy_on_q !== 1'b0; n++) @(negedge clk);
    repeat (hold) @(negedge clk);
    command_strobe = 1'b0;
    point_select_inputs = ~pt;
  endtask : cmd
endmodule : jhs_host_model
`default_nettype wire

// ===== verification/jhs_sequencer_test.sv
/*
  Self-checking bench of the jog and homing sequencer.
  Assumes 50 MHz clock and the host model.
*/
`timescale 1ns/1ps
`default_nettype none
module jhs_sequencer_test;
  import jhs_pkg::*;
  logic clk = 0, rst_n = 0, mf1 = 0, mf2 = 0, strobe, busy, shared, fact, homed;
  logic [5:0] pts, codes, spt;
  logic [7:0] fcode;
  logic signed [31:0] pos;
  jhs_cfg_t cfg;
  jhs_motion_t mot = '0;
  jhs_drive_t drv;
  jhs_home_type_t htype;
  int error_cnt = 0, tests_run = 0;

  // 50 MHz clock
  initial forever #10 clk = ~clk;

  jhs_host_model host (.clk(clk), .busy_on_q(busy), .command_strobe(strobe),
    .point_select_inputs(pts));
  jhs_sequencer DUT (.clk(clk), .rst_n(rst_n), .command_strobe(strobe),
    .point_select_inputs(pts), .multi_function_input_one(mf1),
    .multi_function_input_two(mf2), .cfg(cfg), .mot(mot), .busy_on_q(busy),
    .position_code_outputs_q(codes), .shared_out_q(shared), .drive_q(drv),
    .home_type_q(htype), .step_point_q(spt), .fault_active_q(fact),
    .fault_code_q(fcode), .homing_complete_q(homed), .current_position_q(pos));

  task tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick

  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk

  task give_verdict;
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : give_verdict

  // Bounded wait for busy
  task automatic wait_busy;
    int i;
    for (i = 0; i < 40 && busy !== 1'b1; i++) tick(1);
    if (busy !== 1'b1) begin
      chk("busy_wait", 1, busy);
      give_verdict;
    end
  endtask : wait_busy

  task do_reset;
    rst_n = 0;
    tick(16);
    rst_n = 1;
    tick(3);
  endtask : do_reset

  // Forward jog on point max-1
  task jog(input int incs, input int hold);
    fork
      host.cmd(6'h06, hold);
      begin
        tick(7);
        repeat (incs) begin
          mot.pos_inc = 1;
          tick(1);
          mot.pos_inc = 0;
          tick(1);
        end
      end
    join
    tick(1);
  endtask : jog

  task clear_alarm;
    mot.alarm_clear = 1;
    tick(1);
    mot.alarm_clear = 0;
    wait_busy;
  endtask : clear_alarm

  task t_step_refused;
    do_reset;
    chk("homed_unset", 0, homed);
    host.cmd(6'h03, 0);
    tick(2);
    chk("busy_step", 1, busy);
    $display("test step_refused done");
  endtask : t_step_refused

  task automatic t_home_types;
    int t;
    logic rej;
    cfg.control_mode_setting = 1;
    for (t = 0; t < 8; t++) begin
      cfg.homing_type_setting = jhs_home_type_t'(t[2:0]);
      tick(2);
      host.cmd(6'h07, 0);
      rej = (t == 0 || t == 2 || t == 3 || t == 5);
      chk("fault_active", rej, fact);
      if (rej) begin
        chk("fault_code", FC_HOMING, fcode);
        clear_alarm;
      end else begin
        chk("home_type", t, htype);
        mot.home_done_ok = 1;
        tick(1);
        mot.home_done_ok = 0;
        wait_busy;
        chk("codes_homed", PCODE_HOMED, codes);
      end
      chk("homed", !rej, homed);
    end
    cfg.control_mode_setting = 0;
    $display("test home_types done");
  endtask : t_home_types

  task t_jog;
    cfg.homing_skip_setting = 1;
    cfg.max_plus_travel = 6;
    do_reset;
    chk("homed_skip", 1, homed);
    chk("pos_offset", 5, pos);
    jog(1, 10);
    chk("decel_req", 1, drv.decel_req);
    mot.motion_stopped = 1;
    tick(1);
    mot.motion_stopped = 0;
    wait_busy;
    chk("codes_jog", 6, codes);
    chk("pos_step", 6, pos);
    host.cmd(6'h03, 0);
    chk("step_pt", 3, spt);
    mot.step_done = 1;
    tick(1);
    mot.step_done = 0;
    wait_busy;
    chk("codes_step", 3, codes);
    jog(2, 10);
    chk("limit_code", FC_LIMIT, fcode);
    chk("homed_trip", 0, homed);
    clear_alarm;
    cfg.jog_acceleration = 0;
    jog(0, 2);
    chk("undef_code", FC_UNDEF, fcode);
    cfg.jog_acceleration = 1;
    clear_alarm;
    $display("test jog done");
  endtask : t_jog

  task automatic t_overflow;
    int w;
    cfg.homing_skip_setting = 0;
    cfg.absolute_encoder_setting = ABS_HOMED_B;
    cfg.max_plus_travel = POS_MAX;
    cfg.max_minus_travel = POS_MAX;
    mot.abs_position = POS_MAX;
    for (w = 0; w < 2; w++) begin
      cfg.wrap_around_permit = w[0];
      do_reset;
      chk("homed_abs", 1, homed);
      jog(1, 10);
      chk("ovf_code", w ? FC_NONE : FC_OVF, fcode);
      if (w) chk("pos_wrap", POS_MIN, pos);
    end
    $display("test overflow done");
  endtask : t_overflow

  task t_both_mf;
    cfg.absolute_encoder_setting = 2'h1;
    cfg.mf_one_assign = MF_JOG_FWD;
    cfg.mf_two_assign = MF_JOG_REV;
    do_reset;
    mf1 = 1;
    mf2 = 1;
    mot.positioned = 1;
    host.cmd(6'h00, 2);
    chk("busy_both", 1, busy);
    chk("shared", 1, shared);
    chk("jog_both", 0, drv.jog_fwd | drv.jog_rev);
    $display("test both_mf done");
  endtask : t_both_mf

  // Main sequence
  initial begin
    cfg = '0;
    cfg.jog_low_speed = 16'h0001;
    cfg.jog_high_speed = 16'h0001;
    cfg.jog_acceleration = 16'h0001;
    cfg.jog_deceleration = 16'h0001;
    cfg.absolute_encoder_setting = 2'h1;
    cfg.home_offset_value = 5;
    cfg.max_plus_travel = 1000;
    cfg.max_minus_travel = 1000;
    mot.abs_position = 9;
    t_step_refused;
    t_home_types;
    t_jog;
    t_overflow;
    t_both_mf;
    give_verdict;
  end
endmodule : jhs_sequencer_test
`default_nettype wire
